/* common/cwb_pkg.sv */
`default_nettype none
package cwb_pkg;

  // ==========================================================================
  // Word geometry
  localparam int unsigned CWB_WORD_W  = 24;
  localparam int unsigned CWB_NWORDS  = 7;
  localparam int unsigned CWB_IDX_W   = 3;
  localparam int unsigned CWB_HALF_W  = 16;
  localparam int unsigned CWB_CODE_W  = 3;
  localparam int unsigned CWB_NSETS   = 4;

  typedef logic [CWB_WORD_W-1:0] cwb_word_t;
  typedef logic [CWB_IDX_W-1:0]  cwb_idx_t;

  localparam cwb_word_t CWB_ERASED = 24'hffffff;

  // ==========================================================================
  // Word indices in the storage array
  localparam cwb_idx_t CWB_IDX_WIN_LO  = 3'h0;
  localparam cwb_idx_t CWB_IDX_WIN_HI  = 3'h1;
  localparam cwb_idx_t CWB_IDX_CNT_LO  = 3'h2;
  localparam cwb_idx_t CWB_IDX_CNT_HI  = 3'h3;
  localparam cwb_idx_t CWB_IDX_CTRL    = 3'h4;
  localparam cwb_idx_t CWB_IDX_PINOPT  = 3'h5;
  localparam cwb_idx_t CWB_IDX_SHADOW  = 3'h6;
  localparam cwb_idx_t CWB_IDX_LAST    = 3'h6;

  // ==========================================================================
  // Bus byte offsets
  localparam logic [31:0] CWB_OFS_WIN_LO = 32'h00000000;
  localparam logic [31:0] CWB_OFS_WIN_HI = 32'h00000004;
  localparam logic [31:0] CWB_OFS_CNT_LO = 32'h00000008;
  localparam logic [31:0] CWB_OFS_CNT_HI = 32'h0000000c;
  localparam logic [31:0] CWB_OFS_CTRL   = 32'h00000010;
  localparam logic [31:0] CWB_OFS_PINOPT = 32'h00000014;
  localparam logic [31:0] CWB_OFS_SHADOW = 32'h00000018;

  // ==========================================================================
  // Implemented bit masks; other bits read as one
  localparam cwb_word_t CWB_MASK_HALF   = 24'h00ffff;
  localparam cwb_word_t CWB_MASK_CTRL   = 24'h000001;
  localparam cwb_word_t CWB_MASK_PINOPT = 24'h00279c;
  localparam cwb_word_t CWB_MASK_SHADOW = 24'h007777;

  // ==========================================================================
  // Field positions
  localparam int unsigned CWB_BIT_DM_OFF    = 0;
  localparam int unsigned CWB_BIT_SPI2_PIN  = 13;
  localparam int unsigned CWB_BIT_SMB3      = 10;
  localparam int unsigned CWB_BIT_I2C2_ALT  = 4;
  localparam int unsigned CWB_BIT_I2C1_ALT  = 3;
  localparam int unsigned CWB_LSB_SET4      = 12;
  localparam int unsigned CWB_LSB_SET3      = 8;
  localparam int unsigned CWB_LSB_SET2      = 4;
  localparam int unsigned CWB_LSB_SET1      = 0;

  localparam logic [CWB_CODE_W-1:0] CWB_CODE_NONE = 3'h7;
  localparam logic [CWB_CODE_W-1:0] CWB_CODE_STEP = 3'h1;
  localparam logic [CWB_CODE_W-1:0] CWB_LEVEL_NONE = 3'h0;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    CWB_ST_REQ = 3'b001,
    CWB_ST_CAP = 3'b010,
    CWB_ST_RUN = 3'b100
  } cwb_load_e;

  typedef struct packed {
    logic                  assigned;
    logic [CWB_CODE_W-1:0] level;
  } cwb_shadow_s;

  typedef struct packed {
    logic     we;
    cwb_idx_t idx;
    cwb_word_t data;
  } cwb_prog_s;

endpackage : cwb_pkg
`default_nettype wire

/* hdl/_unused_placeholder_never.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* hdl/cwb_config_bank.sv */
// Functional notes
// RULE1 - Bits program once, erased reads one; bank is read-only at run time.
// RULE2 - Unimplemented bits of every 24-bit word read back as one.
// RULE3 - Window interval bits 15..0 come from low interval word bits 15..0.
// RULE4 - Window interval bits 31..16 come from high interval word bits 15..0.
// RULE5 - Time-out count bits 15..0 come from low count word bits 15..0.
// RULE6 - Time-out count bits 31..16 come from high count word bits 15..0.
// RULE7 - Control word bit 0 one disables the deadman timer, zero enables it.
// RULE8 - Pin option bit 13 one routes second SPI via remappable pins.
// RULE9 - Bit 10 selects new SMBus levels, effective only in SMBus mode.
// RULE10 - Bit 4 one keeps second I2C at default pins, zero alternate.
// RULE11 - Bit 3 one keeps first I2C at default pins, zero alternate.
// RULE12 - Programmer keeps reserved option bits 9..8 zero, bits 7 and 2 one.
// RULE13 - Bits 14..12 map shadow set four to levels 1..7, 111 unassigned.
// RULE14 - Bits 10..8 map shadow set three to levels 1..7, 111 unassigned.
// RULE15 - Bits 6..4 map shadow set two to levels 1..7, 111 unassigned.
// RULE16 - Bits 2..0 map shadow set one to levels 1..7, 111 unassigned.
// RULE17 - Words are loaded after reset before release and held until next reset.
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cwb_config_bank
  import cwb_pkg::*;
(
  input  wire logic          I_CORE_CLK,
  input  wire logic          I_RST_N,
  input  wire logic          I_POR_N,
  // Programmer port
  input  wire logic          I_PROG_WE,
  input  wire logic [2:0]    I_PROG_IDX,
  input  wire logic [23:0]   I_PROG_DATA,
  // SMBus mode from the I2C controller
  input  wire logic          I_SMBUS_MODE_ON,
  // AHB-Lite slave
  input  wire logic          I_HSEL,
  input  wire logic [31:0]   I_HADDR,
  input  wire logic [1:0]    I_HTRANS,
  input  wire logic          I_HWRITE,
  input  wire logic [2:0]    I_HSIZE,
  input  wire logic [31:0]   I_HWDATA,
  input  wire logic          I_HREADY,
  output logic [31:0]        O_HRDATA,
  output logic               O_HREADYOUT,
  output logic               O_HRESP,
  // Configuration outputs
  output logic               O_CFG_VALID,
  output logic [31:0]        O_DEADMAN_WINDOW_INTERVAL,
  output logic [31:0]        O_DEADMAN_COUNT_TIMEOUT,
  output logic               O_DEADMAN_OFF,
  output logic               O_SPI_SECOND_PIN_ROUTE,
  output logic               O_SMBUS_NEW_LEVELS_ON,
  output logic               O_I2C_FIRST_ALT_PINS,
  output logic               O_I2C_SECOND_ALT_PINS,
  output cwb_shadow_s [3:0]  O_SHADOW_SET_LEVEL
);

  // ==========================================================================
  // Helpers
  function automatic cwb_word_t show_word(input cwb_word_t raw, input cwb_word_t mask);
    show_word = (raw & mask) | ~mask;  // [RULE2]
  endfunction : show_word

  cwb_word_t shadow_r [CWB_NWORDS];

  function automatic logic [31:0] read_word(input logic [31:0] addr);
    logic [31:0] data;
    data = 32'h00000000;
    unique case (addr)
      CWB_OFS_WIN_LO: data = {8'h00, show_word(shadow_r[CWB_IDX_WIN_LO], CWB_MASK_HALF)};
      CWB_OFS_WIN_HI: data = {8'h00, show_word(shadow_r[CWB_IDX_WIN_HI], CWB_MASK_HALF)};
      CWB_OFS_CNT_LO: data = {8'h00, show_word(shadow_r[CWB_IDX_CNT_LO], CWB_MASK_HALF)};
      CWB_OFS_CNT_HI: data = {8'h00, show_word(shadow_r[CWB_IDX_CNT_HI], CWB_MASK_HALF)};
      CWB_OFS_CTRL:   data = {8'h00, show_word(shadow_r[CWB_IDX_CTRL], CWB_MASK_CTRL)};
      CWB_OFS_PINOPT: data = {8'h00, show_word(shadow_r[CWB_IDX_PINOPT], CWB_MASK_PINOPT)};
      CWB_OFS_SHADOW: data = {8'h00, show_word(shadow_r[CWB_IDX_SHADOW], CWB_MASK_SHADOW)};
      default:        data = 32'h00000000;
    endcase
    read_word = data;
  endfunction : read_word

  // ==========================================================================
  // Nonvolatile store
  cwb_prog_s prog;
  cwb_idx_t  load_idx_r;
  cwb_word_t store_rd_data;

  assign prog.we   = I_PROG_WE;
  assign prog.idx  = I_PROG_IDX;
  assign prog.data = I_PROG_DATA;

  cwb_otp_store u_store (
    .i_clk     (I_CORE_CLK),
    .i_por_n   (I_POR_N),
    .i_prog    (prog),
    .i_rd_idx  (load_idx_r),
    .o_rd_data (store_rd_data)
  );

  // ==========================================================================
  // Load sequencer: one read then one capture per word
  cwb_load_e state_r;
  cwb_load_e state_nxt;
  cwb_idx_t  load_idx_nxt;

  wire cfg_loaded = (state_r == CWB_ST_RUN);
  wire last_word  = (load_idx_r == CWB_IDX_LAST);
  wire capture    = (state_r == CWB_ST_CAP);

  always_comb begin
    state_nxt    = state_r;
    load_idx_nxt = load_idx_r;
    unique case (state_r)
      CWB_ST_REQ: state_nxt = CWB_ST_CAP;
      CWB_ST_CAP: begin
        if (last_word) begin
          state_nxt = CWB_ST_RUN;
        end else begin
          state_nxt    = CWB_ST_REQ;
          load_idx_nxt = CWB_IDX_W'(load_idx_r + 3'h1);
        end
      end
      CWB_ST_RUN: state_nxt = CWB_ST_RUN;
      default:    state_nxt = CWB_ST_REQ;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      state_r    <= CWB_ST_REQ;  // [RULE17]
      load_idx_r <= CWB_IDX_WIN_LO;
    end else begin
      state_r    <= state_nxt;
      load_idx_r <= load_idx_nxt;
    end
  end

  // Shadow copy only changes while loading, so later programming waits for reset
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      for (int i = 0; i < CWB_NWORDS; i++) begin
        shadow_r[i] <= CWB_ERASED;
      end
    end else if (capture) begin
      shadow_r[load_idx_r] <= store_rd_data;  // [RULE17]
    end
  end

  // ==========================================================================
  // Configuration decode
  wire cwb_word_t win_lo = shadow_r[CWB_IDX_WIN_LO];
  wire cwb_word_t win_hi = shadow_r[CWB_IDX_WIN_HI];
  wire cwb_word_t cnt_lo = shadow_r[CWB_IDX_CNT_LO];
  wire cwb_word_t cnt_hi = shadow_r[CWB_IDX_CNT_HI];
  wire cwb_word_t ctrl   = shadow_r[CWB_IDX_CTRL];
  wire cwb_word_t pinopt = shadow_r[CWB_IDX_PINOPT];
  wire cwb_word_t setmap = shadow_r[CWB_IDX_SHADOW];

  assign O_CFG_VALID               = cfg_loaded;  // [RULE17]
  assign O_DEADMAN_WINDOW_INTERVAL = {win_hi[CWB_HALF_W-1:0],  // [RULE4]
                                      win_lo[CWB_HALF_W-1:0]}; // [RULE3]
  assign O_DEADMAN_COUNT_TIMEOUT   = {cnt_hi[CWB_HALF_W-1:0],  // [RULE6]
                                      cnt_lo[CWB_HALF_W-1:0]}; // [RULE5]
  assign O_DEADMAN_OFF             = ctrl[CWB_BIT_DM_OFF];              // [RULE7]
  assign O_SPI_SECOND_PIN_ROUTE    = pinopt[CWB_BIT_SPI2_PIN];          // [RULE8]
  assign O_SMBUS_NEW_LEVELS_ON     = pinopt[CWB_BIT_SMB3] & I_SMBUS_MODE_ON;  // [RULE9]
  assign O_I2C_SECOND_ALT_PINS     = ~pinopt[CWB_BIT_I2C2_ALT];         // [RULE10]
  assign O_I2C_FIRST_ALT_PINS      = ~pinopt[CWB_BIT_I2C1_ALT];         // [RULE11]

  localparam int unsigned SET_LSB [CWB_NSETS] = '{CWB_LSB_SET1, CWB_LSB_SET2,
                                                 CWB_LSB_SET3, CWB_LSB_SET4};

  for (genvar g = 0; g < CWB_NSETS; g++) begin : g_set
    cwb_level_dec u_dec (
      .i_code (setmap[SET_LSB[g] +: CWB_CODE_W]),  // [RULE13] [RULE14] [RULE15] [RULE16]
      .o_map  (O_SHADOW_SET_LEVEL[g])
    );
  end

  // ==========================================================================
  // AHB-Lite slave; writes are accepted and ignored
  logic        dph_valid_r;
  logic        dph_write_r;
  logic [31:0] dph_addr_r;
  logic        data_ok_r;
  logic [31:0] hrdata_r;

  wire accept  = I_HSEL && I_HTRANS[1] && I_HREADY;
  wire pending = dph_valid_r && !data_ok_r;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r  <= 32'h00000000;
      data_ok_r   <= 1'b0;
      hrdata_r    <= 32'h00000000;
    end else if (pending) begin
      // Stalled writes keep returning zero while the load finishes
      data_ok_r <= cfg_loaded;
      hrdata_r  <= dph_write_r ? 32'h00000000 : read_word(dph_addr_r);  // [RULE1]
    end else if (accept) begin
      dph_valid_r <= 1'b1;
      dph_write_r <= I_HWRITE;
      dph_addr_r  <= I_HADDR;
      data_ok_r   <= cfg_loaded;
      hrdata_r    <= I_HWRITE ? 32'h00000000 : read_word(I_HADDR);  // [RULE1]
    end else if (I_HREADY) begin
      dph_valid_r <= 1'b0;
      data_ok_r   <= 1'b0;
    end
  end

  assign O_HREADYOUT = !dph_valid_r || data_ok_r;
  assign O_HRESP     = 1'b0;
  assign O_HRDATA    = hrdata_r;

endmodule : cwb_config_bank
`default_nettype wire

/* hdl/cwb_level_dec.sv */
`timescale 1ns/1ps
`default_nettype none
module cwb_level_dec
  import cwb_pkg::*;
(
  input  wire logic [CWB_CODE_W-1:0] i_code,
  output cwb_shadow_s                o_map
);

  wire                  assigned = (i_code != CWB_CODE_NONE);
  wire [CWB_CODE_W-1:0] level    = CWB_CODE_W'(i_code + CWB_CODE_STEP);

  // Code n selects level n+1, all ones leaves the set free
  assign o_map.assigned = assigned;                               // [RULE13] [RULE14]
  assign o_map.level    = assigned ? level : CWB_LEVEL_NONE;      // [RULE15] [RULE16]

endmodule : cwb_level_dec
`default_nettype wire

/* hdl/cwb_otp_store.sv */
`timescale 1ns/1ps
`default_nettype none
module cwb_otp_store
  import cwb_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_por_n,
  input  wire cwb_prog_s i_prog,
  input  wire cwb_idx_t  i_rd_idx,
  output cwb_word_t      o_rd_data
);

  cwb_word_t mem_r [CWB_NWORDS];
  cwb_word_t rd_data_r;

  wire prog_ok = i_prog.we && (i_prog.idx <= CWB_IDX_LAST);
  wire rd_ok   = (i_rd_idx <= CWB_IDX_LAST);

  // ==========================================================================
  // Program once: a bit only goes from erased one to zero
  always_ff @(posedge i_clk) begin
    if (!i_por_n) begin
      for (int i = 0; i < CWB_NWORDS; i++) begin
        mem_r[i] <= CWB_ERASED;
      end
    end else if (prog_ok) begin
      mem_r[i_prog.idx] <= mem_r[i_prog.idx] & i_prog.data;  // [RULE1]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_por_n) begin
      rd_data_r <= CWB_ERASED;
    end else begin
      rd_data_r <= rd_ok ? mem_r[i_rd_idx] : CWB_ERASED;
    end
  end

  assign o_rd_data = rd_data_r;

endmodule : cwb_otp_store
`default_nettype wire

/* sim/cwb_config_bank_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module cwb_config_bank_checker
  import cwb_pkg::*;
(
  input wire logic              I_CORE_CLK,
  input wire logic              I_RST_N,
  input wire logic              I_SMBUS_MODE_ON,
  input wire logic              I_HSEL,
  input wire logic [31:0]       I_HADDR,
  input wire logic [1:0]        I_HTRANS,
  input wire logic              I_HWRITE,
  input wire logic              I_HREADY,
  input wire logic [31:0]       O_HRDATA,
  input wire logic              O_HREADYOUT,
  input wire logic              O_HRESP,
  input wire logic              O_CFG_VALID,
  input wire logic [31:0]       O_DEADMAN_WINDOW_INTERVAL,
  input wire logic              O_SPI_SECOND_PIN_ROUTE,
  input wire logic              O_SMBUS_NEW_LEVELS_ON,
  input wire logic              O_I2C_FIRST_ALT_PINS,
  input wire logic              O_I2C_SECOND_ALT_PINS,
  input wire cwb_shadow_s [3:0] O_SHADOW_SET_LEVEL
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  // Accepted transfers once the bank is loaded
  wire logic go = I_HSEL & I_HTRANS[1] & I_HREADY & O_CFG_VALID;
  wire logic rd = go & ~I_HWRITE;
  a_resp_okay: assert property (O_HRESP == 1'b0)
    else $error("Response not OKAY");
  a_write_ignored: assert property (go && I_HWRITE |=> O_HRDATA == 32'h0)
    else $error("Write returned data");
  a_win_lo_read: assert property (rd && I_HADDR == CWB_OFS_WIN_LO |=>
    O_HRDATA == {16'h00ff, O_DEADMAN_WINDOW_INTERVAL[15:0]}) else $error("Bad low window");
  a_win_hi_read: assert property (rd && I_HADDR == CWB_OFS_WIN_HI |=>
    O_HRDATA == {16'h00ff, O_DEADMAN_WINDOW_INTERVAL[31:16]}) else $error("Bad high window");
  a_pinopt_read: assert property (rd && I_HADDR == CWB_OFS_PINOPT |=>
    O_HRDATA[13] == O_SPI_SECOND_PIN_ROUTE && O_HRDATA[4] != O_I2C_SECOND_ALT_PINS
    && O_HRDATA[3] != O_I2C_FIRST_ALT_PINS) else $error("Bad option read");
  a_smbus_gated: assert property (O_SMBUS_NEW_LEVELS_ON |-> I_SMBUS_MODE_ON)
    else $error("Levels on outside SMBus mode");
  a_set_coding: assert property (
    O_SHADOW_SET_LEVEL[0].assigned == (O_SHADOW_SET_LEVEL[0].level != 3'h0)
    && O_SHADOW_SET_LEVEL[3].assigned == (O_SHADOW_SET_LEVEL[3].level != 3'h0))
    else $error("Bad set coding");
  a_set_read: assert property (rd && I_HADDR == CWB_OFS_SHADOW |=>
    O_SHADOW_SET_LEVEL[0].assigned == (O_HRDATA[2:0] != 3'h7)
    && O_SHADOW_SET_LEVEL[3].assigned == (O_HRDATA[14:12] != 3'h7))
    else $error("Bad set map read");
  a_load_bound: assert property ($rose(I_RST_N) |-> !O_CFG_VALID ##[1:20] O_CFG_VALID)
    else $error("Load too slow");
  a_cfg_hold: assert property (O_CFG_VALID |=> O_CFG_VALID &&
    $stable(O_DEADMAN_WINDOW_INTERVAL)) else $error("Config changed");
  a_ready_loaded: assert property (O_CFG_VALID && $past(O_CFG_VALID) |-> O_HREADYOUT)
    else $error("Stall after load");
endmodule : cwb_config_bank_checker
bind cwb_config_bank cwb_config_bank_checker u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
  .I_SMBUS_MODE_ON(I_SMBUS_MODE_ON), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
  .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP), .O_CFG_VALID(O_CFG_VALID),
  .O_DEADMAN_WINDOW_INTERVAL(O_DEADMAN_WINDOW_INTERVAL),
  .O_SPI_SECOND_PIN_ROUTE(O_SPI_SECOND_PIN_ROUTE), .O_SMBUS_NEW_LEVELS_ON(O_SMBUS_NEW_LEVELS_ON),
  .O_I2C_FIRST_ALT_PINS(O_I2C_FIRST_ALT_PINS), .O_I2C_SECOND_ALT_PINS(O_I2C_SECOND_ALT_PINS),
  .O_SHADOW_SET_LEVEL(O_SHADOW_SET_LEVEL));
`default_nettype wire

/* sim/cwb_config_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cwb_config_bank_bench
  import cwb_pkg::*;
;
  logic              clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, we = 1'b0, smb = 1'b0;
  logic [2:0]        idx = 3'h0;
  logic [23:0]       pdata = 24'h0;
  logic              hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]        htrans = 2'b00;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, win, cnt;
  logic              hready, hresp, valid, dm_off, spi, smb_new, i2c1, i2c2;
  cwb_shadow_s [3:0] sets;
  cwb_word_t         store [7];
  cwb_word_t         mask [7] = '{CWB_MASK_HALF, CWB_MASK_HALF, CWB_MASK_HALF, CWB_MASK_HALF,
                                  CWB_MASK_CTRL, CWB_MASK_PINOPT, CWB_MASK_SHADOW};
  int                seed = 32'h63e4, err_count = 0, total_checks = 0;

  cwb_config_bank u_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_POR_N(por_n), .I_PROG_WE(we),
    .I_PROG_IDX(idx), .I_PROG_DATA(pdata), .I_SMBUS_MODE_ON(smb), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_CFG_VALID(valid), .O_DEADMAN_WINDOW_INTERVAL(win), .O_DEADMAN_COUNT_TIMEOUT(cnt),
    .O_DEADMAN_OFF(dm_off), .O_SPI_SECOND_PIN_ROUTE(spi), .O_SMBUS_NEW_LEVELS_ON(smb_new),
    .O_I2C_FIRST_ALT_PINS(i2c1), .O_I2C_SECOND_ALT_PINS(i2c2), .O_SHADOW_SET_LEVEL(sets));

  always #5 clk = ~clk;

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic prog(input logic [2:0] i, input cwb_word_t d);
    @(posedge clk);
    we <= 1'b1;
    idx <= i;
    pdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : prog

  task automatic pulse(input logic erase);
    @(posedge clk);
    if (erase) por_n <= 1'b0;
    else rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
  endtask : pulse

  function automatic logic [31:0] exp_rd(input int i);
    if (i > 6) return 32'h0;
    return {8'h00, (store[i] & mask[i]) | ~mask[i]};
  endfunction : exp_rd

  function automatic cwb_shadow_s exp_set(input logic [2:0] c);
    exp_set.assigned = (c != 3'h7);
    exp_set.level = (c == 3'h7) ? 3'h0 : c + 3'h1;
  endfunction : exp_set

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Tests: pass 0 stays erased, later passes program random words
  initial begin : main
    logic [31:0] rd;
    cwb_word_t   w;
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    for (int n = 0; n < 9; n++) begin
      if (n > 0) pulse(1'b1);
      for (int i = 0; i < 7; i++) begin
        w = 24'($random(seed));
        if (i == 5) w = (w & 24'hfffcff) | 24'h000084;
        if (i == 6) w = {w[23:15], 3'(n + 2), w[11], 3'(n + 1), w[7], 3'(n), w[3], 3'(n - 1)};
        store[i] = (n == 0) ? CWB_ERASED : w;
        if (n > 0) prog(3'(i), w);
      end
      if (n > 0) begin
        w = 24'($random(seed));
        store[1] &= w;
        prog(3'h1, w);
        prog(3'h7, 24'h0);
      end
      pulse(1'b0);
      if (n[0]) begin
        ahb(1'b1, 32'h0, 32'h0, rd);
        check(rd, 32'h0);
      end
      for (int i = 0; i < 8; i++) begin
        ahb(1'b0, 32'(i * 4), 32'h0, rd);
        check(rd, exp_rd(i));
      end
      for (int m = 0; m < 2; m++) begin
        @(posedge clk);
        smb <= m[0];
        @(negedge clk);
        check(win, {store[1][15:0], store[0][15:0]});
        check(cnt, {store[3][15:0], store[2][15:0]});
        check({dm_off, spi, smb_new, i2c2, i2c1}, {store[4][0], store[5][13],
          store[5][10] & smb, ~store[5][4], ~store[5][3]});
        for (int g = 0; g < 4; g++)
          check(32'(sets[g]), 32'(exp_set(store[6][4*g +: 3])));
      end
      ahb(1'b1, 32'h0, 32'(~exp_rd(0)), rd);
      check(rd, 32'h0);
      prog(3'h0, 24'h0);
      ahb(1'b0, 32'h0, 32'h0, rd);
      check(rd, exp_rd(0));
      check(win, {store[1][15:0], store[0][15:0]});
      $display("Test %0d done", n);
    end
    give_verdict();
  end

  initial begin : watchdog
    #100000;
    err_count++;
    give_verdict();
  end
endmodule : cwb_config_bank_bench
`default_nettype wire
